// *** wdog_pkg.sv ***
// Purpose: shared constants for the watchdog and clock monitor block
// Assumes: 32-bit Avalon-MM register bus, word aligned byte addresses
// Notes: control bit positions and register offsets are fixed here; the control read view repeats the bit order by hand
package wdog_pkg;
	// ************************************************************
	// register map (byte addresses)
	// ************************************************************
	localparam logic [3:0] ADDR_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_SERVICE = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	localparam logic [3:0] ADDR_TEST = 4'hC;
	// ************************************************************
	// control register fields
	// ************************************************************
	localparam int BIT_MON_EN = 7;
	localparam int BIT_FORCE_MON_EN = 6;
	localparam int BIT_FORCE_MON_RST = 5;
	localparam int BIT_FORCE_WD_RST = 4;
	localparam int BIT_RST_DISABLE = 3;
	localparam int RATE_LSB = 0;
	localparam int RATE_W = 3;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	// ************************************************************
	// status and test register fields
	// ************************************************************
	localparam int BIT_ARMED = 0;
	localparam int BIT_WD_CAUSE = 1;
	localparam int BIT_MON_CAUSE = 2;
	localparam int BIT_SPECIAL = 3;
	localparam int BIT_BYPASS = 0;
	// ************************************************************
	// service values and divider figures
	// ************************************************************
	localparam logic [7:0] SERVICE_ARM = 8'h55;
	localparam logic [7:0] SERVICE_FIRE = 8'hAA;
	localparam int PRESCALE_BITS = 13;
	localparam int BYPASS_BITS = 2;
	localparam int TIMEOUT_BITS = 10;
	localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ANSWER = 2'b10
	} bus_state_t;
endpackage

// *** wdog_prescale.sv ***
// Purpose: fixed pre-divider of the bus clock feeding the watchdog chain
// Assumes: ce freezes the counter
// Notes: bypass keeps only the first two stages (count bits 1:0) for test speed-up
`timescale 1ns/1ps
module wdog_prescale #(
	parameter int PRE_BITS = wdog_pkg::PRESCALE_BITS
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic bypass,
	output logic tick
);
	import wdog_pkg::*;
	logic [PRE_BITS-1:0] count;
	wire full_wrap = &count;
	wire short_wrap = &count[BYPASS_BITS-1:0];
	wire next_tick = bypass ? short_wrap : full_wrap;
	// ************************************************************
	// free-running divider, tick once per wrap
	// ************************************************************
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			count <= '0;
			tick <= 1'b0;
		end else if (ce) begin
			count <= count + 1'b1;
			tick <= next_tick;
		end
	end
endmodule

// *** wdog_timeout.sv ***
// Purpose: watchdog timeout counter driven by prescaler ticks
// Assumes: tick is a one-cycle pulse, rate code 0 stops the count
// Notes: expire is a one-cycle pulse in the cycle after the last tick of the period
`timescale 1ns/1ps
module wdog_timeout #(
	parameter int CNT_BITS = wdog_pkg::TIMEOUT_BITS
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic tick,
	input wire logic restart,
	input wire logic [wdog_pkg::RATE_W-1:0] rate,
	output logic expire
);
	import wdog_pkg::*;
	logic [CNT_BITS-1:0] count;
	// extra division after the prescaler, in ticks
	function automatic logic [CNT_BITS:0] span(input logic [RATE_W-1:0] code);
		unique case (code)
			3'h1: span = (CNT_BITS+1)'(1);
			3'h2: span = (CNT_BITS+1)'(4);
			3'h3: span = (CNT_BITS+1)'(16);
			3'h4: span = (CNT_BITS+1)'(64);
			3'h5: span = (CNT_BITS+1)'(256);
			3'h6: span = (CNT_BITS+1)'(512);
			3'h7: span = (CNT_BITS+1)'(1024);
			default: span = '0;
		endcase
	endfunction
	wire enabled = rate != '0;
	wire last = ({1'b0, count} == span(rate) - 1'b1);
	// ************************************************************
	// count ticks, expire at the selected division
	// ************************************************************
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			count <= '0;
			expire <= 1'b0;
		end else if (ce) begin
			expire <= enabled && tick && last && !restart;
			if (!enabled || restart || (tick && last))
				count <= '0;
			else if (tick)
				count <= count + 1'b1;
		end
	end
endmodule

// *** wdog_monitor.sv ***
// Purpose: watchdog and clock-loss monitor control with Avalon-MM registers
// Assumes: special_mode, clock_slow and stop_active are synchronous levels
// Notes: clock_slow comes from a delay cell that runs without device clocks
//
// The Avalon-MM register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module wdog_monitor (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic special_mode,
	input wire logic clock_slow,
	input wire logic stop_active,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic watchdog_reset,
	output logic monitor_reset,
	output logic system_reset,
	output logic watchdog_active,
	output logic monitor_active
);
	import wdog_pkg::*;

	// ************************************************************
	// state
	// ************************************************************
	bus_state_t bus_state;
	bus_state_t next_bus_state;
	logic clock_monitor_enable;
	logic force_monitor_enable;
	logic reset_disable;
	logic [RATE_W-1:0] watchdog_rate;
	logic divider_bypass;
	logic force_enable_written;
	logic rate_written;
	logic armed;
	logic wd_cause;
	logic mon_cause;
	logic pre_tick;
	logic expire;

	// ************************************************************
	// bus decode
	// ************************************************************
	// a request is taken at the edge where waitrequest is seen low
	wire request = avs_read | avs_write;
	wire take = request && (bus_state == BUS_ANSWER);
	wire wr_take = take && avs_write;
	wire lane0 = avs_byteenable[0];
	wire hit_control = avs_address == ADDR_CONTROL;
	wire hit_service = avs_address == ADDR_SERVICE;
	wire hit_status = avs_address == ADDR_STATUS;
	wire hit_test = avs_address == ADDR_TEST;
	wire [7:0] wbyte = avs_writedata[7:0];

	// write strobes, low byte lane only
	wire wr_control = wr_take && hit_control && lane0;
	wire wr_service = wr_take && hit_service && lane0;
	wire wr_status = wr_take && hit_status && lane0;
	wire wr_test = wr_take && hit_test && lane0;

	// ************************************************************
	// write permission by operating mode
	// ************************************************************
	// forced enable: once in normal mode, any time in special mode
	wire force_en_may = special_mode || !force_enable_written;
	// rate select: once in normal mode, any time in special mode
	wire rate_may = special_mode || !rate_written;
	// special-mode-only fields
	wire test_may = special_mode;

	// ************************************************************
	// service sequence decode
	// ************************************************************
	wire svc_arm = wr_service && (wbyte == SERVICE_ARM);
	wire svc_fire = wr_service && (wbyte == SERVICE_FIRE);
	wire svc_bad = wr_service && !svc_arm && !svc_fire;
	// a completed pair only when armed beforehand
	wire svc_done = svc_fire && armed;

	// ************************************************************
	// enables and fault sources
	// ************************************************************
	// forced enable overrides the enable bit
	wire mon_on = force_monitor_enable | clock_monitor_enable;
	wire wd_on = watchdog_rate != '0;
	// loss flag from the clock-independent delay cell, stop counted as loss
	wire clock_lost = clock_slow | stop_active;
	// forced resets act only in special mode
	wire force_mon = wr_control && test_may && wbyte[BIT_FORCE_MON_RST];
	wire force_wd = wr_control && test_may && wbyte[BIT_FORCE_WD_RST];
	wire mon_fault = mon_on && (clock_lost || force_mon);
	wire wd_fault = svc_bad || (wd_on && (expire || force_wd));
	// reset disable blocks both resets whatever else is set
	wire mon_fire = mon_fault && !reset_disable;
	wire wd_fire = wd_fault && !reset_disable;

	// ************************************************************
	// read mux
	// ************************************************************
	wire [7:0] control_view = {clock_monitor_enable, force_monitor_enable, 1'b0, 1'b0,
		reset_disable, watchdog_rate};
	wire [7:0] status_view = {4'h0, special_mode, mon_cause, wd_cause, armed};
	wire [7:0] test_view = {7'h00, divider_bypass};
	// service register always reads zero
	wire [31:0] next_readdata = hit_control ? {24'h00_0000, control_view} :
		hit_status ? {24'h00_0000, status_view} :
		hit_test ? {24'h00_0000, test_view} :
		READ_UNMAPPED;

	// ************************************************************
	// bus handshake state machine
	// ************************************************************
	// one idle cycle, then waitrequest low for exactly one cycle
	always_comb begin
		next_bus_state = bus_state;
		unique case (bus_state)
			BUS_IDLE: begin
				if (request)
					next_bus_state = BUS_ANSWER;
			end
			BUS_ANSWER: begin
				next_bus_state = BUS_IDLE;
			end
			default: begin
				next_bus_state = BUS_IDLE;
			end
		endcase
	end

	// state and bus outputs
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			bus_state <= BUS_IDLE;
			avs_waitrequest <= 1'b1;
			avs_readdata <= '0;
		end else if (ce) begin
			bus_state <= next_bus_state;
			avs_waitrequest <= !(bus_state == BUS_IDLE && request);
			if (bus_state == BUS_IDLE && avs_read)
				avs_readdata <= next_readdata;
		end
	end

	// ************************************************************
	// control register
	// ************************************************************
	// monitor enable is free to write; the rest follow mode permission
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			clock_monitor_enable <= CONTROL_RESET[BIT_MON_EN];
			force_monitor_enable <= CONTROL_RESET[BIT_FORCE_MON_EN];
			reset_disable <= CONTROL_RESET[BIT_RST_DISABLE];
			watchdog_rate <= CONTROL_RESET[RATE_LSB+:RATE_W];
		end else if (ce && wr_control) begin
			clock_monitor_enable <= wbyte[BIT_MON_EN];
			if (force_en_may)
				force_monitor_enable <= wbyte[BIT_FORCE_MON_EN];
			if (test_may)
				reset_disable <= wbyte[BIT_RST_DISABLE];
			if (rate_may)
				watchdog_rate <= wbyte[RATE_LSB+:RATE_W];
		end
	end

	// write-once tracking, armed by the first write in normal mode
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			force_enable_written <= 1'b0;
			rate_written <= 1'b0;
		end else if (ce && wr_control && !special_mode) begin
			force_enable_written <= 1'b1;
			rate_written <= 1'b1;
		end
	end

	// ************************************************************
	// test register
	// ************************************************************
	always_ff @(posedge sys_clk) begin
		if (rst)
			divider_bypass <= 1'b0;
		else if (ce && wr_test && test_may)
			divider_bypass <= wbyte[BIT_BYPASS];
	end

	// ************************************************************
	// service sequence
	// ************************************************************
	// first step arms, a completed second step disarms
	always_ff @(posedge sys_clk) begin
		if (rst)
			armed <= 1'b0;
		else if (ce) begin
			if (svc_arm)
				armed <= 1'b1;
			else if (svc_done || svc_bad)
				armed <= 1'b0;
		end
	end

	// ************************************************************
	// reset cause flags, write one to clear, set wins
	// ************************************************************
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wd_cause <= 1'b0;
			mon_cause <= 1'b0;
		end else if (ce) begin
			if (wd_fire)
				wd_cause <= 1'b1;
			else if (wr_status && wbyte[BIT_WD_CAUSE])
				wd_cause <= 1'b0;
			if (mon_fire)
				mon_cause <= 1'b1;
			else if (wr_status && wbyte[BIT_MON_CAUSE])
				mon_cause <= 1'b0;
		end
	end

	// ************************************************************
	// timing chain
	// ************************************************************
	// bypass counts only in special mode
	wire bypass_live = divider_bypass && special_mode;
	wdog_prescale #(
		.PRE_BITS(PRESCALE_BITS)
	) u_prescale (
		.sys_clk(sys_clk),
		.rst(rst),
		.ce(ce),
		.bypass(bypass_live),
		.tick(pre_tick)
	);

	// timeout restarts only on a completed pair
	wdog_timeout #(
		.CNT_BITS(TIMEOUT_BITS)
	) u_timeout (
		.sys_clk(sys_clk),
		.rst(rst),
		.ce(ce),
		.tick(pre_tick),
		.restart(svc_done),
		.rate(watchdog_rate),
		.expire(expire)
	);

	// ************************************************************
	// reset outputs
	// ************************************************************
	// one-cycle pulses per fault cycle; system reset is their union
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			watchdog_reset <= 1'b0;
			monitor_reset <= 1'b0;
			system_reset <= 1'b0;
			watchdog_active <= 1'b0;
			monitor_active <= 1'b0;
		end else if (ce) begin
			watchdog_reset <= wd_fire;
			monitor_reset <= mon_fire;
			system_reset <= wd_fire || mon_fire;
			watchdog_active <= wd_on;
			monitor_active <= mon_on;
		end
	end
endmodule

// *** wdog_monitor_asserts.sv ***
// Purpose: concurrent checks on the ports of the watchdog and monitor block
// Assumes: one clock domain, synchronous active high reset, ce held high
// Notes: dis mirrors the reset disable bit from accepted special-mode writes
`timescale 1ns/1ps
module wdog_monitor_asserts (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic special_mode,
	input wire logic clock_slow,
	input wire logic stop_active,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic watchdog_reset,
	input wire logic monitor_reset,
	input wire logic system_reset,
	input wire logic watchdog_active,
	input wire logic monitor_active
);
	import wdog_pkg::*;
	logic dis;
	// accepted writes and the byte they carry
	wire wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
	wire ctl_wr = wr_ok && special_mode && avs_address == ADDR_CONTROL;
	wire [7:0] wd = avs_writedata[7:0];
	// shadow of the reset disable bit
	always_ff @(posedge sys_clk) begin
		if (rst)
			dis <= 1'b0;
		else if (ctl_wr)
			dis <= wd[BIT_RST_DISABLE];
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence wd_pulse;
		##[1:2] watchdog_reset;
	endsequence
	sequence mon_off2;
		!monitor_active ##1 !monitor_active;
	endsequence
	a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[0:2] !avs_waitrequest)
		else $error("request left without answer");
	a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_service_zero: assert property (avs_read && !avs_waitrequest && avs_address == ADDR_SERVICE |-> avs_readdata == 32'h0)
		else $error("service register read not zero");
	a_bad_service: assert property (wr_ok && avs_address == ADDR_SERVICE && wd != SERVICE_ARM && wd != SERVICE_FIRE && !dis |-> wd_pulse)
		else $error("bad service value without reset");
	a_force_watchdog: assert property (ctl_wr && wd[BIT_FORCE_WD_RST] && !wd[BIT_RST_DISABLE] && !dis && watchdog_active && wd[2:0] != 3'h0 |-> wd_pulse)
		else $error("forced watchdog reset missing");
	a_force_monitor: assert property (ctl_wr && wd[BIT_FORCE_MON_RST] && !wd[BIT_RST_DISABLE] && !dis && monitor_active && wd[BIT_MON_EN] |-> ##[1:2] monitor_reset)
		else $error("forced monitor reset missing");
	a_clock_loss: assert property (monitor_active && (clock_slow || stop_active) && !dis && !$past(dis) |-> ##[1:2] monitor_reset)
		else $error("clock loss without monitor reset");
	a_monitor_off: assert property (mon_off2 |-> !monitor_reset)
		else $error("monitor reset while monitor off");
	a_disable_quiet: assert property (dis && $past(dis) |-> !system_reset)
		else $error("system reset while disabled");
	a_reset_clean: assert property ($fell(rst) |-> avs_waitrequest && !system_reset && !watchdog_active && !monitor_active)
		else $error("outputs not clear after reset");
endmodule
bind wdog_monitor wdog_monitor_asserts chk (.sys_clk(sys_clk), .rst(rst),
	.special_mode(special_mode), .clock_slow(clock_slow), .stop_active(stop_active),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.watchdog_reset(watchdog_reset), .monitor_reset(monitor_reset),
	.system_reset(system_reset), .watchdog_active(watchdog_active),
	.monitor_active(monitor_active));

// *** watchdog_and_clock_monitor_test.sv ***
// Purpose: self-checking bench for the watchdog and clock monitor block
// Assumes: ce and byte enables held high, Avalon master with waitrequest
// Notes: timeout rows use the prescaler bypass except the last one
`timescale 1ns/1ps
module watchdog_and_clock_monitor_test;
	import wdog_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic special_mode = 1'b0;
	logic clock_slow = 1'b0;
	logic stop_active = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, watchdog_reset, monitor_reset, system_reset;
	logic watchdog_active, monitor_active;
	int failures = 0;
	int checked = 0;
	int wd_n = 0;
	int mon_n = 0;
	int sys_n = 0;
	int n, c, d;
	logic [7:0] q;
	// bypass, rate code, expected cycles to expiry
	int rows[8][3] = '{'{1, 1, 4}, '{1, 2, 16}, '{1, 3, 64}, '{1, 4, 256},
		'{1, 5, 1024}, '{1, 6, 2048}, '{1, 7, 4096}, '{0, 1, 8192}};
	wdog_monitor DUT (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .special_mode(special_mode),
		.clock_slow(clock_slow), .stop_active(stop_active), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.watchdog_reset(watchdog_reset), .monitor_reset(monitor_reset),
		.system_reset(system_reset), .watchdog_active(watchdog_active),
		.monitor_active(monitor_active));
	// ************************************************************
	// clock and pulse counters
	// ************************************************************
	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		if (watchdog_reset === 1'b1) wd_n <= wd_n + 1;
		if (monitor_reset === 1'b1) mon_n <= mon_n + 1;
		if (system_reset === 1'b1) sys_n <= sys_n + 1;
	end
	// ************************************************************
	// tasks
	// ************************************************************
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_range(input int got, input int lo, input int hi);
		checked++;
		if (got < lo || got > hi) begin
			failures++;
			$display("wrong value at %0t got %h expected %h to %h", $time, got, lo, hi);
		end
	endtask
	// one Avalon transfer held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] v,
		output logic [7:0] r);
		int k;
		@(posedge sys_clk);
		avs_write <= wr;
		avs_read <= !wr;
		avs_address <= a;
		avs_writedata <= {24'h0, v};
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 20);
		r = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (k >= 20) begin
			failures++;
			close_out;
		end
	endtask
	task automatic settle(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask
	task automatic do_reset(input logic sp);
		@(posedge sys_clk);
		rst <= 1'b1;
		special_mode <= sp;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
	endtask
	task automatic wait_wd(output int m);
		m = 0;
		while (watchdog_reset !== 1'b1 && m < 9000) begin
			@(posedge sys_clk);
			m++;
		end
		if (m >= 9000) begin
			failures++;
			close_out;
		end
	endtask
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		for (int i = 0; i < 8; i++) begin
			do_reset(1'b1);
			bus(1'b1, ADDR_TEST, 8'(rows[i][0]), q);
			bus(1'b1, ADDR_CONTROL, 8'(rows[i][1]), q);
			wait_wd(n);
			check_range(n, rows[i][2] - 5, rows[i][2] + 3);
			$display("timeout row %0d done", i);
		end
		// reset values, reads of service and unmapped space
		do_reset(1'b0);
		bus(1'b0, ADDR_CONTROL, 8'h00, q);
		check_val(q, CONTROL_RESET);
		bus(1'b0, ADDR_SERVICE, 8'h00, q);
		check_val(q, 8'h00);
		bus(1'b0, 4'h2, 8'h00, q);
		check_val(q, 8'h00);
		check_val(watchdog_active, 1'b0);
		$display("reset value test done");
		// normal mode: test bits refused, write-once fields lock
		c = wd_n + mon_n;
		bus(1'b1, ADDR_CONTROL, 8'hF9, q);
		settle(4);
		check_val(wd_n + mon_n, c);
		bus(1'b1, ADDR_CONTROL, 8'h05, q);
		bus(1'b0, ADDR_CONTROL, 8'h00, q);
		check_val(q, 8'h41);
		check_val(monitor_active, 1'b1);
		c = mon_n;
		@(posedge sys_clk) clock_slow <= 1'b1;
		settle(4);
		check_val(mon_n > c, 1'b1);
		@(posedge sys_clk) clock_slow <= 1'b0;
		$display("normal mode test done");
		// bad service value with the watchdog off
		do_reset(1'b0);
		c = wd_n;
		bus(1'b1, ADDR_SERVICE, 8'h12, q);
		settle(3);
		check_val(wd_n, c + 1);
		$display("bad service test done");
		// service pair restarts, a lone second step does not
		do_reset(1'b1);
		bus(1'b1, ADDR_TEST, 8'h01, q);
		bus(1'b1, ADDR_CONTROL, 8'h04, q);
		c = wd_n;
		settle(150);
		bus(1'b1, ADDR_SERVICE, SERVICE_ARM, q);
		bus(1'b1, ADDR_SERVICE, SERVICE_FIRE, q);
		settle(150);
		check_val(wd_n, c);
		bus(1'b1, ADDR_SERVICE, SERVICE_FIRE, q);
		wait_wd(n);
		check_range(n, 60, 150);
		$display("service test done");
		// reset disable blocks bad service and clock loss resets; the force bits are written while monitor and watchdog are off
		do_reset(1'b1);
		bus(1'b1, ADDR_CONTROL, 8'h08, q);
		n = sys_n;
		c = wd_n;
		d = mon_n;
		bus(1'b1, ADDR_SERVICE, 8'h12, q);
		bus(1'b1, ADDR_CONTROL, 8'hB9, q);
		@(posedge sys_clk) clock_slow <= 1'b1;
		settle(6);
		check_val(wd_n - c + mon_n - d, 0);
		check_val(sys_n, n);
		$display("reset disable test done");
		@(posedge sys_clk) clock_slow <= 1'b0;
		// forced resets in special mode, then stop with monitor off and on
		do_reset(1'b1);
		c = wd_n;
		d = mon_n;
		n = sys_n;
		// the watchdog must already run when the force bit is written
		bus(1'b1, ADDR_CONTROL, 8'h81, q);
		bus(1'b1, ADDR_CONTROL, 8'h91, q);
		bus(1'b1, ADDR_CONTROL, 8'hA1, q);
		bus(1'b1, ADDR_CONTROL, 8'h01, q);
		settle(3);
		check_val(wd_n, c + 1);
		check_val(mon_n, d + 1);
		check_val(sys_n, n + 2);
		// both cause flags set, then cleared by writing ones
		bus(1'b0, ADDR_STATUS, 8'h00, q);
		check_val(q, 8'h0E);
		bus(1'b1, ADDR_STATUS, 8'h06, q);
		bus(1'b0, ADDR_STATUS, 8'h00, q);
		check_val(q, 8'h08);
		@(posedge sys_clk) stop_active <= 1'b1;
		settle(5);
		check_val(mon_n, d + 1);
		bus(1'b1, ADDR_CONTROL, 8'h81, q);
		settle(5);
		check_val(mon_n > d + 1, 1'b1);
		@(posedge sys_clk) stop_active <= 1'b0;
		$display("special mode test done");
		close_out;
	end
endmodule
